// file: dv/isc_bus_peer.sv
// Far-side peer on the open-drain clock line
`timescale 1ns/1ps
module isc_bus_peer (
	// Design side of the pin
	input wire logic scl_out_q,
	input wire logic scl_oe_n_q,
	// Peer holds the line low to slow the master
	input wire logic stretch,
	// Resolved line
	output logic scl_in
);
	// Pull-up wins only when nobody pulls low
	assign scl_in = (!scl_oe_n_q && !scl_out_q) || stretch ? 1'b0 : 1'b1;
endmodule

// file: dv/isc_status_clock_reset_monitor.sv
// Port checker for the status, clock and reset block
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_status_clock_reset_monitor #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU port
	input wire logic [ADDR_W-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata_q,
	// Events and control bits
	input wire logic state_enter,
	input wire logic [7:0] state_enter_code,
	input wire logic bus_error,
	input wire logic irq_clear,
	input wire logic halt_request,
	input wire logic begin_request,
	// Status outputs
	input wire logic irq_pending_q,
	input wire logic err_hold_q,
	input wire logic recover_start_q,
	input wire logic soft_reset_q,
	input wire logic scl_oe_n_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic srst;
	assign srst = io_wr && io_addr == `ISC_OFS_SOFT_RESET;
	sequence s_rec;
		err_hold_q && irq_clear && halt_request && begin_request
			&& !bus_error && !srst;
	endsequence
	sequence s_restart;
		!err_hold_q ##1 recover_start_q ##1 !recover_start_q;
	endsequence
	property p_low;
		io_rdata_q[2:0] == 3'h0;
	endproperty
	a_low: assert property (p_low) else $error("low bits set");
	property p_unmapped;
		io_rd && io_addr != `ISC_OFS_STATE |=> io_rdata_q == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_idle;
		state_enter && state_enter_code == `ISC_C_IDLE && !irq_pending_q
			&& !bus_error && !srst |=> !irq_pending_q;
	endproperty
	a_idle: assert property (p_idle) else $error("idle set flag");
	property p_enter;
		state_enter && state_enter_code == `ISC_C_START && !err_hold_q
			&& !bus_error && !srst |=> irq_pending_q;
	endproperty
	a_enter: assert property (p_enter) else $error("flag not set");
	property p_clear;
		irq_clear && !state_enter && !bus_error |=> !irq_pending_q;
	endproperty
	a_clear: assert property (p_clear) else $error("flag kept");
	property p_err;
		bus_error && !srst |=> irq_pending_q && err_hold_q;
	endproperty
	a_err: assert property (p_err) else $error("error missed");
	property p_rec;
		s_rec |=> s_restart;
	endproperty
	a_rec: assert property (p_rec) else $error("bad restart");
	property p_hold;
		irq_pending_q && !srst |=> !scl_oe_n_q;
	endproperty
	a_hold: assert property (p_hold) else $error("clock released");
	property p_srst;
		srst |=> soft_reset_q && !irq_pending_q && !err_hold_q
			##1 !soft_reset_q;
	endproperty
	a_srst: assert property (p_srst) else $error("bad reset");
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the status, clock and reset block
`timescale 1ns/1ps
`include "isc_params.svh"
module tb_top;
	logic clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, state_enter = 0;
	logic bus_error = 0, master_mode = 0, irq_clear = 0, stretch = 0;
	logic halt_request = 0, begin_request = 0, scl_in;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00, state_enter_code = 8'h00, io_rdata_q;
	logic irq_pending_q, err_hold_q, recover_start_q, soft_reset_q;
	logic samp_tick_q, scl_rise_q, scl_out_q, scl_oe_n_q;
	int n_errors = 0, compares = 0;
	int n_rise;
	isc_status_clock_reset u_isc_status_clock_reset (
		.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
		.state_enter(state_enter), .state_enter_code(state_enter_code),
		.bus_error(bus_error), .master_mode(master_mode),
		.irq_clear(irq_clear), .halt_request(halt_request),
		.begin_request(begin_request), .irq_pending_q(irq_pending_q),
		.err_hold_q(err_hold_q), .recover_start_q(recover_start_q),
		.soft_reset_q(soft_reset_q), .samp_tick_q(samp_tick_q),
		.scl_rise_q(scl_rise_q), .scl_in(scl_in), .scl_out_q(scl_out_q),
		.scl_oe_n_q(scl_oe_n_q));
	isc_bus_peer u_isc_bus_peer (.scl_out_q(scl_out_q),
		.scl_oe_n_q(scl_oe_n_q), .stretch(stretch), .scl_in(scl_in));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		tick();
		s = 1;
		tick();
		s = 0;
	endtask
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		tick();
		io_wr = 1;
		io_addr = a;
		io_wdata = d;
		tick();
		io_wr = 0;
	endtask
	task automatic io_read(input logic [15:0] a, input logic [7:0] exp);
		tick();
		io_rd = 1;
		io_addr = a;
		tick();
		io_rd = 0;
		chk(io_rdata_q, exp);
	endtask
	// Spacing in clocks between two pulses of a divider output
	task automatic gap(input logic sel, input int exp);
		int n;
		for (n = 0; n < 400 && (sel ? scl_rise_q : samp_tick_q) !== 1'b1; n++)
			tick();
		tick();
		for (n = 1; n < 400 && (sel ? scl_rise_q : samp_tick_q) !== 1'b1; n++)
			tick();
		if (n >= 400) begin
			n_errors++;
			print_verdict();
		end else begin
			chk(8'(n), 8'(exp));
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		io_read(`ISC_OFS_STATE, `ISC_C_IDLE);
		for (int i = 1; i < 28; i++) begin
			state_enter_code = 8'(i * 8);
			pulse(state_enter);
			chk({7'h00, irq_pending_q}, 8'h01);
			io_read(`ISC_OFS_STATE, state_enter_code);
			pulse(irq_clear);
			io_read(`ISC_OFS_STATE, `ISC_C_IDLE);
		end
		state_enter_code = `ISC_C_IDLE;
		pulse(state_enter);
		chk({7'h00, irq_pending_q}, 8'h00);
		// Undefined code must be dropped like the idle code
		state_enter_code = 8'h0C;
		pulse(state_enter);
		chk({7'h00, irq_pending_q}, 8'h00);
		pulse(bus_error);
		chk({6'h00, irq_pending_q, err_hold_q}, 8'h03);
		io_read(`ISC_OFS_STATE, `ISC_C_BUS_ERROR);
		state_enter_code = `ISC_C_START;
		pulse(state_enter);
		io_read(`ISC_OFS_STATE, `ISC_C_BUS_ERROR);
		pulse(irq_clear);
		chk({6'h00, irq_pending_q, err_hold_q}, 8'h01);
		halt_request = 1;
		pulse(irq_clear);
		chk({6'h00, irq_pending_q, err_hold_q}, 8'h00);
		pulse(bus_error);
		begin_request = 1;
		pulse(irq_clear);
		tick();
		chk({7'h00, recover_start_q}, 8'h01);
		begin_request = 0;
		halt_request = 0;
		master_mode = 1;
		// Bit 7 set on purpose: it must not reach the scalar
		// Sampling 5 MHz against a 250 kHz bus clock keeps a twenty-fold margin
		io_write(`ISC_OFS_DIVIDER, 8'h89);
		io_read(`ISC_OFS_STATE, `ISC_C_IDLE);
		io_read(16'h00CB, 8'h00);
		gap(1'b0, 2);
		gap(1'b1, 40);
		// Peer holds the line low in the high phase: no rise may follow
		stretch = 1;
		n_rise = 0;
		repeat (100) begin
			tick();
			if (scl_rise_q === 1'b1)
				n_rise++;
		end
		chk(8'(n_rise), 8'h00);
		stretch = 0;
		gap(1'b1, 40);
		state_enter_code = `ISC_C_START;
		pulse(state_enter);
		tick();
		chk({6'h00, scl_oe_n_q, scl_out_q}, 8'h00);
		io_write(`ISC_OFS_SOFT_RESET, 8'h5A);
		chk({6'h00, irq_pending_q, soft_reset_q}, 8'h01);
		io_read(`ISC_OFS_STATE, `ISC_C_IDLE);
		gap(1'b0, 1);
		print_verdict();
	end
endmodule
bind isc_status_clock_reset isc_status_clock_reset_monitor
	#(.ADDR_W(ADDR_W)) u_isc_status_clock_reset_monitor (
	.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
	.io_rd(io_rd), .io_rdata_q(io_rdata_q), .state_enter(state_enter),
	.state_enter_code(state_enter_code), .bus_error(bus_error),
	.irq_clear(irq_clear), .halt_request(halt_request),
	.begin_request(begin_request), .irq_pending_q(irq_pending_q),
	.err_hold_q(err_hold_q), .recover_start_q(recover_start_q),
	.soft_reset_q(soft_reset_q), .scl_oe_n_q(scl_oe_n_q));

// file: logic/isc_params.svh
// Offsets, field layouts, reset values and state codes of the status block
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

`define ISC_OFS_STATE 16'h00CC
`define ISC_OFS_DIVIDER 16'h00CC
`define ISC_OFS_SOFT_RESET 16'h00CD

`define ISC_STATE_MSB 7
`define ISC_STATE_LSB 3
`define ISC_SCALAR_MSB 6
`define ISC_SCALAR_LSB 3
`define ISC_EXP_MSB 2
`define ISC_EXP_LSB 0

`define ISC_STATE_RESET 8'hF8
`define ISC_DIVIDER_RESET 7'h00

`define ISC_SCL_HALF_MULT 7'h05

`define ISC_C_BUS_ERROR 8'h00
`define ISC_C_START 8'h08
`define ISC_C_RESTART 8'h10
`define ISC_C_AW_ACK 8'h18
`define ISC_C_AW_NACK 8'h20
`define ISC_C_MTX_ACK 8'h28
`define ISC_C_MTX_NACK 8'h30
`define ISC_C_ARB_LOST 8'h38
`define ISC_C_AR_ACK 8'h40
`define ISC_C_AR_NACK 8'h48
`define ISC_C_MRX_ACK 8'h50
`define ISC_C_MRX_NACK 8'h58
`define ISC_C_SW_ACK 8'h60
`define ISC_C_SW_ARB 8'h68
`define ISC_C_GC_ACK 8'h70
`define ISC_C_GC_ARB 8'h78
`define ISC_C_SRX_ACK 8'h80
`define ISC_C_SRX_NACK 8'h88
`define ISC_C_GRX_ACK 8'h90
`define ISC_C_GRX_NACK 8'h98
`define ISC_C_SLV_STOP 8'hA0
`define ISC_C_SR_ACK 8'hA8
`define ISC_C_SR_ARB 8'hB0
`define ISC_C_STX_ACK 8'hB8
`define ISC_C_STX_NACK 8'hC0
`define ISC_C_STX_LAST 8'hC8
`define ISC_C_A2_ACK 8'hD0
`define ISC_C_A2_NACK 8'hD8
`define ISC_C_IDLE 8'hF8

`endif

// file: logic/isc_pkg.sv
// Types shared by the status, clock and reset block
package isc_pkg;
	typedef logic [7:0] isc_code_t;
	typedef enum logic [2:0] {
		ISC_RUN = 3'b001,
		ISC_ERR = 3'b010,
		ISC_RESTART = 3'b100
	} isc_err_e;
endpackage

// file: logic/isc_status_clock_reset.sv
// Status code, clock divider and software reset of the two-wire controller
`timescale 1ns/1ps
`include "isc_params.svh"

module isc_status_clock_reset
	import isc_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU I/O register port
	input wire logic [ADDR_W-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_q,
	// Byte engine events
	input wire logic state_enter,
	input wire logic [7:0] state_enter_code,
	input wire logic bus_error,
	input wire logic master_mode,
	// Control register side
	input wire logic irq_clear,
	input wire logic halt_request,
	input wire logic begin_request,
	output logic irq_pending_q,
	output logic err_hold_q,
	output logic recover_start_q,
	output logic soft_reset_q,
	// Clock enables for the byte engine
	output logic samp_tick_q,
	output logic scl_rise_q,
	// Serial clock pin, open drain
	input wire logic scl_in,
	output logic scl_out_q,
	output logic scl_oe_n_q
);

	// Address compare needs at least the 8-bit offsets
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
		$error("isc_status_clock_reset: ADDR_W must be 8 to 32");
	end

	isc_code_t state_q;
	logic [6:0] divider_q;
	isc_err_e err_q;
	logic sw_rst;
	logic hit_state;
	logic hit_reset;
	logic code_ok;
	logic [2:0] exponent;
	logic [3:0] scalar;
	logic [7:0] samp_span;
	logic [6:0] samp_lim;
	logic [6:0] samp_cnt_q;
	logic samp_tick;
	logic [6:0] half_lim;
	logic [6:0] half_cnt_q;
	logic scl_phase_q;
	logic scl_sync1_q;
	logic scl_sync2_q;
	logic drive_low;
	logic stalled;
	logic err_exit;
	logic [2:0] own_low_q;

	// Address decode
	always_comb begin
		hit_state = 1'b0;
		hit_reset = 1'b0;
		if (io_addr == ADDR_W'(`ISC_OFS_STATE)) begin
			hit_state = 1'b1;
		end else if (io_addr == ADDR_W'(`ISC_OFS_SOFT_RESET)) begin
			hit_reset = 1'b1;
		end
	end

	// Any value written clears the block next edge
	assign sw_rst = io_wr && hit_reset;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= sw_rst;
		end
	end

	// Only the defined codes may be shown; anything else is dropped
	always_comb begin
		case (state_enter_code)
			`ISC_C_START,
			`ISC_C_RESTART,
			`ISC_C_AW_ACK,
			`ISC_C_AW_NACK,
			`ISC_C_MTX_ACK,
			`ISC_C_MTX_NACK,
			`ISC_C_ARB_LOST: code_ok = 1'b1;
			`ISC_C_AR_ACK,
			`ISC_C_AR_NACK,
			`ISC_C_MRX_ACK,
			`ISC_C_MRX_NACK: code_ok = 1'b1;
			`ISC_C_SW_ACK,
			`ISC_C_SW_ARB,
			`ISC_C_GC_ACK,
			`ISC_C_GC_ARB: code_ok = 1'b1;
			`ISC_C_SRX_ACK,
			`ISC_C_SRX_NACK,
			`ISC_C_GRX_ACK,
			`ISC_C_GRX_NACK,
			`ISC_C_SLV_STOP: code_ok = 1'b1;
			`ISC_C_SR_ACK,
			`ISC_C_SR_ARB,
			`ISC_C_STX_ACK,
			`ISC_C_STX_NACK,
			`ISC_C_STX_LAST: code_ok = 1'b1;
			`ISC_C_A2_ACK,
			`ISC_C_A2_NACK: code_ok = 1'b1;
			default: code_ok = 1'b0;
		endcase
	end

	// Error exit needs the stop request with the flag clear
	assign err_exit = (err_q == ISC_ERR) && irq_clear && halt_request;

	// Bus error tracking and recovery
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= ISC_RUN;
		end else if (sw_rst) begin
			err_q <= ISC_RUN;
		end else begin
			case (err_q)
				ISC_RUN: begin
					if (bus_error) begin
						err_q <= ISC_ERR;
					end
				end
				ISC_ERR: begin
					if (bus_error) begin
						err_q <= ISC_ERR;
					end else if (err_exit && begin_request) begin
						err_q <= ISC_RESTART;
					end else if (err_exit) begin
						err_q <= ISC_RUN;
					end
				end
				ISC_RESTART: begin
					if (bus_error) begin
						err_q <= ISC_ERR;
					end else begin
						err_q <= ISC_RUN;
					end
				end
				default: begin
					err_q <= ISC_RUN;
				end
			endcase
		end
	end

	// Held through the error so the engine never sends a stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_hold_q <= 1'b0;
		end else if (sw_rst) begin
			err_hold_q <= 1'b0;
		end else begin
			err_hold_q <= bus_error || (err_q == ISC_ERR && !err_exit);
		end
	end

	// Start issued after returning to idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recover_start_q <= 1'b0;
		end else if (sw_rst) begin
			recover_start_q <= 1'b0;
		end else begin
			recover_start_q <= (err_q == ISC_RESTART);
		end
	end

	// State code; a new event wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `ISC_STATE_RESET;
		end else if (sw_rst) begin
			state_q <= `ISC_STATE_RESET;
		end else if (bus_error) begin
			state_q <= `ISC_C_BUS_ERROR;
		end else if (state_enter && code_ok && err_q != ISC_ERR) begin
			state_q <= state_enter_code;
		end else if (irq_clear) begin
			state_q <= `ISC_C_IDLE;
		end
	end

	// Interrupt flag, never set by the idle code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_pending_q <= 1'b0;
		end else if (sw_rst) begin
			irq_pending_q <= 1'b0;
		end else if (bus_error) begin
			irq_pending_q <= 1'b1;
		end else if (state_enter && code_ok && err_q != ISC_ERR) begin
			irq_pending_q <= 1'b1;
		end else if (irq_clear) begin
			irq_pending_q <= 1'b0;
		end
	end

	// Divider write-only, bit 7 dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divider_q <= `ISC_DIVIDER_RESET;
		end else if (sw_rst) begin
			divider_q <= `ISC_DIVIDER_RESET;
		end else if (io_wr && hit_state) begin
			divider_q <= io_wdata[6:0];
		end
	end

	assign scalar = divider_q[`ISC_SCALAR_MSB:`ISC_SCALAR_LSB];
	assign exponent = divider_q[`ISC_EXP_MSB:`ISC_EXP_LSB];

	// Read data; only the state register answers, bits 2:0 forced low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_q <= 8'h00;
		end else if (io_rd && hit_state) begin
			io_rdata_q <= {state_q[`ISC_STATE_MSB:`ISC_STATE_LSB], 3'h0};
		end else begin
			io_rdata_q <= 8'h00;
		end
	end

	// Sample prescaler: 2^N clocks per tick
	assign samp_span = 8'h01 << exponent;
	assign samp_lim = 7'(samp_span - 8'h01);
	// Compare by range so a smaller exponent written mid-count never wraps
	assign samp_tick = (samp_cnt_q >= samp_lim);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_cnt_q <= 7'h00;
		end else if (sw_rst || samp_tick) begin
			samp_cnt_q <= 7'h00;
		end else begin
			samp_cnt_q <= samp_cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_tick_q <= 1'b0;
		end else begin
			samp_tick_q <= samp_tick && !sw_rst;
		end
	end

	// Serial clock line sampled before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync1_q <= 1'b1;
			scl_sync2_q <= 1'b1;
		end else begin
			scl_sync1_q <= scl_in;
			scl_sync2_q <= scl_sync1_q;
		end
	end

	// Half period of 5*(M+1) sample ticks gives 10*(M+1) per full period
	assign half_lim = 7'(`ISC_SCL_HALF_MULT * (7'(scalar) + 7'h01) - 7'h01);

	// Own drive delayed like the pin path and synchroniser, so our own
	// release is never taken for a stretch and the period stays exact
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			own_low_q <= 3'h0;
		end else begin
			own_low_q <= {own_low_q[1:0], drive_low};
		end
	end

	// Another device stretching the low phase stalls our count
	assign stalled = scl_phase_q && !scl_sync2_q && !own_low_q[2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt_q <= 7'h00;
			scl_phase_q <= 1'b1;
		end else if (sw_rst || !master_mode || irq_pending_q) begin
			half_cnt_q <= 7'h00;
			scl_phase_q <= 1'b1;
		end else if (samp_tick && !stalled) begin
			if (half_cnt_q >= half_lim) begin
				half_cnt_q <= 7'h00;
				scl_phase_q <= !scl_phase_q;
			end else begin
				half_cnt_q <= half_cnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_rise_q <= 1'b0;
		end else begin
			scl_rise_q <= master_mode && !irq_pending_q && !sw_rst
				&& samp_tick && !stalled && !scl_phase_q
				&& half_cnt_q >= half_lim;
		end
	end

	// Stretch the low phase while the flag is pending
	assign drive_low = irq_pending_q || (master_mode && !scl_phase_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_oe_n_q <= 1'b1;
			scl_out_q <= 1'b0;
		end else begin
			scl_oe_n_q <= !drive_low;
			scl_out_q <= 1'b0;
		end
	end

endmodule
